// ---- logic/npw_addr.sv ----
`timescale 1ns/1ps
// ==========================================
// Entry address former
module npw_addr #(
    parameter int PA_W = 48
) (
    input  wire logic [63:0] base_ent,
    input  wire logic [8:0]  idx,
    output logic      [63:0] ent_addr
);
    // Keeps base bits below the physical width
    localparam logic [39:0] BASE_MASK = 40'(({40{1'b1}}) >> (52 - PA_W));

    // Top zero, masked base, index, 8-byte aligned
    assign ent_addr = {12'h000, base_ent[51:12] & BASE_MASK,
                       idx, 3'h0};
endmodule

// ---- logic/npw_ahb.sv ----
`timescale 1ns/1ps
`include "npw_defs.svh"
// ==========================================
// AHB-Lite register slave, zero wait states
module npw_ahb #(
    parameter int PA_W = 48
) (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    output logic             xl_en,
    output logic      [63:0] root_ptr,
    input  wire logic        busy,
    input  wire logic        flt,
    input  wire logic [1:0]  flt_lvl,
    input  wire logic [15:0] walks
);
    logic [31:0] ctrl_ff;     // Control word
    logic [63:0] root_ff;     // Root pointer
    logic        wr_pend_ff;  // Write data phase due
    logic [7:0]  wr_addr_ff;  // Latched write offset
    logic [31:0] hrdata_ff;   // Registered read data
    logic [31:0] rd_val;      // Read mux
    logic        acc;         // Valid address phase

    assign acc       = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_ff;
    assign root_ptr  = root_ff;
    // Both enables must be on
    assign xl_en = ctrl_ff[`NPW_CTRL_EN_BIT] & ctrl_ff[`NPW_CTRL_PRI_BIT];

    // ==========================================
    // Address phase capture for writes
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
        end else begin
            wr_pend_ff <= acc & hwrite & (hsize == `NPW_HSIZE_WORD);
            wr_addr_ff <= haddr[7:0];
        end
    end

    // Data phase register writes
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctrl_ff <= 32'h00000000;
            root_ff <= 64'h0000000000000000;
        end else if (wr_pend_ff) begin
            case (wr_addr_ff)
                `NPW_OFF_CTRL:    ctrl_ff        <= hwdata;
                `NPW_OFF_ROOT_LO: root_ff[31:0]  <= hwdata;
                `NPW_OFF_ROOT_HI: root_ff[63:32] <= hwdata;
                default: ; // Read-only or unmapped
            endcase
        end
    end

    // Read mux; unmapped reads zero
    always_comb begin
        rd_val = 32'h00000000;
        case (haddr[7:0])
            `NPW_OFF_CTRL:    rd_val = ctrl_ff;
            `NPW_OFF_ROOT_LO: rd_val = root_ff[31:0];
            `NPW_OFF_ROOT_HI: rd_val = root_ff[63:32];
            `NPW_OFF_STAT:    rd_val = {walks, 10'h000, flt_lvl, 2'h0, flt, busy};
            `NPW_OFF_IDQ:     rd_val = {24'h000000, 8'(PA_W)};
            default:          rd_val = 32'h00000000;
        endcase
    end

    // Read data latched at address phase
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            hrdata_ff <= 32'h00000000;
        end else if (acc & !hwrite) begin
            hrdata_ff <= rd_val;
        end
    end
endmodule

// ---- logic/npw_defs.svh ----
`ifndef NPW_DEFS_SVH
`define NPW_DEFS_SVH
// Operation
// - Only guest address bits 47:0 are used
// - At most three entries before the final one
// - First entry: root 51:12, gpa 47:39, zero low
// - Second entry: parent 51:12, gpa 38:30 index
// - Directory entry: parent 51:12, gpa 29:21 index
// - Directory bit 7 clear: fetch leaf, gpa 20:12
// - Small page: leaf 51:12 plus gpa 11:0
// - Directory bit 7 set: entry 51:21, gpa 20:0
// - Bits 63:52 of every formed address zero
// - Bits 2:0 zero means absent, raises violation
// - Each table is 512 aligned 8-byte entries
// - First-level bits 0..2 grant read, write, fetch
// - First-level base in N-1:12, others unused
// - N is the reported physical width, bits 7:0
// - Absent first-level entry is never followed
// - Second-level bits 0..2 grant access rights
// - Second-level directory base in bits N-1:12
// - Walker works only while both enables set
// - Leaf bits 0..2 grant rights for its page
// - Disallowed access reported as a violation

// ==========================================
// Register offsets (byte addresses)
`define NPW_OFF_CTRL    8'h00
`define NPW_OFF_ROOT_LO 8'h04
`define NPW_OFF_ROOT_HI 8'h08
`define NPW_OFF_STAT    8'h0C
`define NPW_OFF_IDQ     8'h10
// ==========================================
// Fields and values
`define NPW_CTRL_EN_BIT  0
`define NPW_CTRL_PRI_BIT 31
`define NPW_LARGE_BIT    7
`define NPW_PA_W         48
`define NPW_HSIZE_WORD   3'h2
`define NPW_LAST_LVL     2'h3
`define NPW_DIR_LVL      2'h2
`define NPW_PERM_ALL     3'h7
`endif

// ---- logic/npw_pkg.sv ----
package npw_pkg;
    // Walker sequencing states
    typedef enum logic [1:0] {
        NPW_IDLE  = 2'b00,
        NPW_FETCH = 2'b01,
        NPW_WAIT  = 2'b10
    } npw_state_t;
endpackage

// ---- logic/npw_walker.sv ----
`timescale 1ns/1ps
`include "npw_defs.svh"
// ==========================================
// Nested page walker, top level
module npw_walker
    import npw_pkg::*;
#(
    parameter int PA_W = `NPW_PA_W
) (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic [63:0] req_gpa,
    input  wire logic [2:0]  req_acc,
    output logic             rsp_valid,
    output logic      [63:0] rsp_pa,
    output logic      [2:0]  rsp_perm,
    output logic             rsp_fault,
    output logic             mem_req_valid,
    input  wire logic        mem_req_ready,
    output logic      [63:0] mem_req_addr,
    input  wire logic        mem_rsp_valid,
    input  wire logic [63:0] mem_rsp_data
);
    // ==========================================
    // Declarations
    npw_state_t  state_ff;      // Walk sequencer
    logic [1:0]  lvl_ff;        // Level being read
    logic [47:0] gpa_ff;        // Captured guest address
    logic [2:0]  acc_ff;        // Requested access kind
    logic [2:0]  perm_ff;       // Rights gathered so far
    logic [63:0] addr_ff;       // Entry address out
    logic        rsp_valid_ff;  // Answer strobe
    logic [63:0] rsp_pa_ff;     // Answer address
    logic [2:0]  rsp_perm_ff;   // Answer rights
    logic        rsp_fault_ff;  // Answer violation
    logic        flt_ff;        // Last walk faulted
    logic [1:0]  flt_lvl_ff;    // Level where last walk ended
    logic [15:0] walks_ff;      // Completed walks
    logic        xl_en;         // Translation enabled
    logic [63:0] root_ptr;      // walk_root_pointer
    logic        take;          // Request accepted
    logic        ent_in;        // Entry arrived
    logic        ent_absent;    // Entry not present
    logic        ent_large;     // Directory maps big page
    logic        ent_last;      // Entry ends the walk
    logic [2:0]  perm_new;      // Rights incl. this entry
    logic        perm_bad;      // Access not permitted
    logic [1:0]  nxt_lvl;       // Level of next read
    logic [47:0] gsrc;          // Guest address source
    logic [63:0] src;           // Parent entry source
    logic [8:0]  idx;           // Table index
    logic [63:0] ent_addr;      // Formed entry address

    // ==========================================
    // Register slave
    npw_ahb #(
        .PA_W (PA_W)
    ) i_npw_ahb (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .xl_en     (xl_en),
        .root_ptr  (root_ptr),
        .busy      (state_ff != NPW_IDLE),
        .flt       (flt_ff),
        .flt_lvl   (flt_lvl_ff),
        .walks     (walks_ff)
    );

    // ==========================================
    // Entry decode
    assign take       = req_valid & req_ready;
    assign ent_in     = (state_ff == NPW_WAIT) & mem_rsp_valid;
    assign ent_absent = mem_rsp_data[2:0] == 3'h0;
    // Rights narrow at every level
    assign perm_new   = perm_ff & mem_rsp_data[2:0];
    assign ent_large  = (lvl_ff == `NPW_DIR_LVL) & mem_rsp_data[`NPW_LARGE_BIT];
    // Depth four, fourth entry is final
    assign ent_last   = ent_large | (lvl_ff == `NPW_LAST_LVL);
    assign perm_bad   = |(acc_ff & ~perm_new);

    // Next level and its sources
    assign nxt_lvl = (state_ff == NPW_IDLE) ? 2'h0 : 2'(lvl_ff + 2'h1);
    assign gsrc    = (state_ff == NPW_IDLE) ? req_gpa[47:0] : gpa_ff;
    assign src     = (state_ff == NPW_IDLE) ? root_ptr : mem_rsp_data;

    // Index slice per level
    always_comb begin
        idx = 9'h000;
        unique case (nxt_lvl)
            2'h0: idx = gsrc[47:39];
            2'h1: idx = gsrc[38:30];
            2'h2: idx = gsrc[29:21];
            2'h3: idx = gsrc[20:12];
        endcase
    end

    // Address former, also yields page frame
    npw_addr #(
        .PA_W (PA_W)
    ) i_npw_addr (
        .base_ent (src),
        .idx      (idx),
        .ent_addr (ent_addr)
    );

    // ==========================================
    // Handshake outputs
    assign req_ready     = state_ff == NPW_IDLE;
    assign mem_req_valid = state_ff == NPW_FETCH;
    assign mem_req_addr  = addr_ff;
    assign rsp_valid     = rsp_valid_ff;
    assign rsp_pa        = rsp_pa_ff;
    assign rsp_perm      = rsp_perm_ff;
    assign rsp_fault     = rsp_fault_ff;

    // ==========================================
    // Sequencer
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_ff <= NPW_IDLE;
        end else begin
            unique case (state_ff)
                NPW_IDLE: begin
                    // Disabled requests answer at once
                    if (take && xl_en) begin
                        state_ff <= NPW_FETCH;
                    end
                end
                NPW_FETCH: begin
                    if (mem_req_ready) begin
                        state_ff <= NPW_WAIT;
                    end
                end
                NPW_WAIT: begin
                    if (ent_in && (ent_absent || ent_last)) begin
                        state_ff <= NPW_IDLE;
                    end else if (ent_in) begin
                        state_ff <= NPW_FETCH;
                    end
                end
                default: state_ff <= NPW_IDLE; // Illegal code
            endcase
        end
    end

    // Level and entry address
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            lvl_ff  <= 2'h0;
            addr_ff <= 64'h0000000000000000;
        end else if (take) begin
            lvl_ff  <= 2'h0;
            addr_ff <= ent_addr;
        end else if (ent_in && !ent_absent && !ent_last) begin
            // Follow only present entries
            lvl_ff  <= nxt_lvl;
            addr_ff <= ent_addr;
        end
    end

    // Request capture and gathered rights
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            gpa_ff  <= 48'h000000000000;
            acc_ff  <= 3'h0;
            perm_ff <= 3'h0;
        end else if (take) begin
            gpa_ff  <= req_gpa[47:0];
            acc_ff  <= req_acc;
            perm_ff <= `NPW_PERM_ALL;
        end else if (ent_in) begin
            perm_ff <= perm_new;
        end
    end

    // Answer to the core
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rsp_valid_ff <= 1'b0;
            rsp_pa_ff    <= 64'h0000000000000000;
            rsp_perm_ff  <= 3'h0;
            rsp_fault_ff <= 1'b0;
        end else begin
            rsp_valid_ff <= 1'b0;
            if (take && !xl_en) begin
                // Pass-through while disabled
                rsp_valid_ff <= 1'b1;
                rsp_pa_ff    <= {16'h0000, req_gpa[47:0]};
                rsp_perm_ff  <= `NPW_PERM_ALL;
                rsp_fault_ff <= 1'b0;
            end else if (ent_in && ent_absent) begin
                // Absent entry, no address given
                rsp_valid_ff <= 1'b1;
                rsp_pa_ff    <= 64'h0000000000000000;
                rsp_perm_ff  <= 3'h0;
                rsp_fault_ff <= 1'b1;
            end else if (ent_in && ent_large) begin
                rsp_valid_ff <= 1'b1;
                rsp_pa_ff    <= {ent_addr[63:21], gpa_ff[20:0]};
                rsp_perm_ff  <= perm_new;
                rsp_fault_ff <= perm_bad;
            end else if (ent_in && ent_last) begin
                rsp_valid_ff <= 1'b1;
                rsp_pa_ff    <= {ent_addr[63:12], gpa_ff[11:0]};
                rsp_perm_ff  <= perm_new;
                rsp_fault_ff <= perm_bad;
            end
        end
    end

    // Status for software
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            flt_ff     <= 1'b0;
            flt_lvl_ff <= 2'h0;
            walks_ff   <= 16'h0000;
        end else if (ent_in && (ent_absent || ent_last)) begin
            flt_ff     <= ent_absent | perm_bad;
            flt_lvl_ff <= lvl_ff;
            walks_ff   <= 16'(walks_ff + 16'h0001);
        end
    end

    // ==========================================
    // Assertions
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    // Reads per walk, helper counter
    logic [2:0] rd_cnt_ff;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rd_cnt_ff <= 3'h0;
        end else if (take) begin
            rd_cnt_ff <= 3'h0;
        end else if (mem_req_valid && mem_req_ready) begin
            rd_cnt_ff <= 3'(rd_cnt_ff + 3'h1);
        end
    end

    walk_depth_a: assert property (rd_cnt_ff <= 3'h4)
        else $error("more than four entry reads in one walk");
    root_index_a: assert property (
        take && xl_en |=> mem_req_valid && mem_req_addr[11:3] == $past(req_gpa[47:39]))
        else $error("first entry index wrong");
    entry_align_a: assert property (
        mem_req_valid |-> mem_req_addr[2:0] == 3'h0 && mem_req_addr[63:52] == 12'h000)
        else $error("entry address not aligned or high bits set");
    mid_index_a: assert property (
        mem_req_valid && lvl_ff == 2'h1 |-> mem_req_addr[11:3] == gpa_ff[38:30])
        else $error("second level index wrong");
    dir_index_a: assert property (
        mem_req_valid && lvl_ff == 2'h2 |-> mem_req_addr[11:3] == gpa_ff[29:21])
        else $error("directory index wrong");
    leaf_index_a: assert property (
        mem_req_valid && lvl_ff == 2'h3 |-> mem_req_addr[11:3] == gpa_ff[20:12])
        else $error("leaf index wrong");
    absent_fault_a: assert property (
        ent_in && ent_absent |=> rsp_valid && rsp_fault && state_ff == NPW_IDLE)
        else $error("absent entry not reported");
    large_page_a: assert property (
        ent_in && !ent_absent && ent_large |=> rsp_valid
            && rsp_pa[20:0] == $past(gpa_ff[20:0]) && rsp_pa[63:52] == 12'h000)
        else $error("large page address wrong");
    small_page_a: assert property (
        ent_in && !ent_absent && lvl_ff == 2'h3 |=> rsp_valid
            && rsp_pa[11:0] == $past(gpa_ff[11:0]))
        else $error("small page offset wrong");
    disabled_pass_a: assert property (
        take && !xl_en |=> rsp_valid && !rsp_fault && !mem_req_valid)
        else $error("disabled request not passed through");
    single_read_a: assert property (
        mem_req_valid && mem_req_ready |=> !mem_req_valid [*1] ##0 state_ff == NPW_WAIT)
        else $error("second read issued before answer");

    large_done_c: cover property (ent_in && ent_large && !ent_absent);
    small_done_c: cover property (ent_in && lvl_ff == 2'h3 && !ent_absent && !perm_bad);
    absent_c:     cover property (ent_in && ent_absent);
    deny_c:       cover property (ent_in && ent_last && !ent_absent && perm_bad);
endmodule

// ---- test/npw_mem_model.sv ----
`timescale 1ns/1ps
// ==========
// Memory path model serving table entries
module npw_mem_model (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic [3:0]  lat,
    input  wire logic        mem_req_valid,
    output logic             mem_req_ready,
    input  wire logic [63:0] mem_req_addr,
    output logic             mem_rsp_valid,
    output logic      [63:0] mem_rsp_data
);
    logic [63:0] tbl [logic [63:0]]; // Entry store, missing reads as zero
    logic [63:0] log_q [$];          // Entry addresses seen, in order
    logic [63:0] a;                  // Address of the read in flight

    // One read at a time, answered after lat extra cycles
    initial begin
        mem_req_ready = 1'b1;
        mem_rsp_valid = 1'b0;
        mem_rsp_data  = 64'h5A5A_5A5A_5A5A_5A5A;
        forever begin
            @(posedge clk_sys);
            if (rstn === 1'b1 && mem_req_valid === 1'b1) begin
                a = mem_req_addr;
                log_q.push_back(a);
                mem_req_ready <= 1'b0;
                repeat (lat) @(posedge clk_sys);
                mem_rsp_valid <= 1'b1;
                mem_rsp_data  <= tbl.exists(a) ? tbl[a] : 64'h0;
                @(posedge clk_sys);
                // Released data must not look like the last entry
                mem_rsp_valid <= 1'b0;
                mem_rsp_data  <= ~mem_rsp_data;
                mem_req_ready <= 1'b1;
            end
        end
    end
endmodule

// ---- test/tb_nested_page_walker.sv ----
`timescale 1ns/1ps
`include "npw_defs.svh"
// ==========
// Self-checking bench for the nested page walker
module tb_nested_page_walker;
    localparam int          PA_W  = `NPW_PA_W;
    localparam logic [39:0] PMASK = (40'h1 << (PA_W - 12)) - 40'h1; // Base bits kept
    localparam logic [63:0] ROOT  = 64'hABC0_0000_1234_5FFF;        // Junk high and low
    localparam logic [63:0] GA    = 64'hFFFF_0123_4567_89AB;        // Small page address
    localparam logic [63:0] GB    = GA ^ 64'h0000_0000_0220_0000;   // Large page address
    localparam logic [63:0] GC    = GA ^ 64'h0000_0000_0000_3000;   // Missing leaf
    localparam logic [63:0] GD    = GA ^ 64'h0000_0080_0000_0000;   // Missing first level
    localparam logic [63:0] E0    = 64'hFFF0_0000_0011_1F07;
    localparam logic [63:0] E1    = 64'h000F_0000_0022_2003;
    localparam logic [63:0] E2    = 64'h0000_0000_0033_3F07;
    localparam logic [63:0] E3    = 64'h0000_0000_0044_4005;

    logic        clk_sys = 1'b0;
    logic        rstn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize, req_acc, rsp_perm;
    logic        req_valid, req_ready, rsp_valid, rsp_fault, en;
    logic [63:0] req_gpa, rsp_pa, mem_req_addr, mem_rsp_data;
    logic        mem_req_valid, mem_req_ready, mem_rsp_valid;
    logic [3:0]  lat;                // Memory answer delay
    int          fails, n_checks;    // Mismatches and comparisons

    assign hready = hreadyout;       // Single slave drives bus ready

    npw_walker #(.PA_W(PA_W)) i_npw_walker (
        .clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .req_valid(req_valid), .req_ready(req_ready), .req_gpa(req_gpa),
        .req_acc(req_acc), .rsp_valid(rsp_valid), .rsp_pa(rsp_pa),
        .rsp_perm(rsp_perm), .rsp_fault(rsp_fault), .mem_req_valid(mem_req_valid),
        .mem_req_ready(mem_req_ready), .mem_req_addr(mem_req_addr),
        .mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data));

    npw_mem_model i_mem (
        .clk_sys(clk_sys), .rstn(rstn), .lat(lat), .mem_req_valid(mem_req_valid),
        .mem_req_ready(mem_req_ready), .mem_req_addr(mem_req_addr),
        .mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data));

    // 200 MHz clock
    always #2.5 clk_sys = ~clk_sys;

    // ==========
    // Compare and verdict
    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wrap_up;
        if (fails == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ==========
    // Register bus master, one word transfer
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        do @(posedge clk_sys); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk_sys); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic ahb_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        ahb(1'b0, a, 32'h0);
        chk(nm, {32'h0, exp}, {32'h0, rd});
        chk("hresp", 64'h0, {63'h0, hresp});
    endtask

    // ==========
    // Reference walk helpers
    function automatic logic [63:0] ea(input logic [63:0] b, input logic [63:0] g,
                                       input int k);
        ea = {12'h0, b[51:12] & PMASK, g[47-9*k -: 9], 3'h0};
    endfunction

    // Store a chain of entries along the walk of g
    task automatic put(input logic [63:0] g, input int n,
                       input logic [63:0] e0, e1, e2, e3);
        logic [63:0] e [4];
        logic [63:0] b;
        e = '{e0, e1, e2, e3};
        b = ROOT;
        for (int k = 0; k < n; k++) begin
            i_mem.tbl[ea(b, g, k)] = e[k];
            b = e[k];
        end
    endtask

    // One translation, checked against the reference walk
    task automatic walk(input logic [63:0] g, input logic [2:0] acc, input logic [3:0] lt);
        logic [63:0] ad [4];
        logic [63:0] b, e, pa;
        logic [2:0]  pm;
        logic        ft, ab, dn;
        int          n, w;
        b = ROOT;
        pa = {16'h0, g[47:0]};
        pm = 3'h7;
        ab = 1'b0;
        dn = 1'b0;
        n = 0;
        for (int k = 0; k < 4 && en && !dn; k++) begin
            ad[k] = ea(b, g, k);
            e = i_mem.tbl.exists(ad[k]) ? i_mem.tbl[ad[k]] : 64'h0;
            n++;
            b = e;
            pm &= e[2:0];
            if (e[2:0] == 3'h0) begin
                ab = 1'b1;
                dn = 1'b1;
            end else if (k == 3) begin
                pa = {12'h0, e[51:12] & PMASK, g[11:0]};
            end else if (k == 2 && e[7]) begin
                pa = {12'h0, e[51:21] & PMASK[39:9], g[20:0]};
                dn = 1'b1;
            end
        end
        if (ab) begin
            pa = 64'h0;
        end
        ft = ab || ((acc & ~pm) != 3'h0);
        i_mem.log_q.delete();
        lat       <= lt;
        req_valid <= 1'b1;
        req_gpa   <= g;
        req_acc   <= acc;
        do @(posedge clk_sys); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        w = 0;
        do begin
            @(posedge clk_sys);
            w++;
        end while (rsp_valid !== 1'b1 && w < 500);
        chk("rsp_valid", 64'h1, {63'h0, rsp_valid});
        chk("rsp_fault", {63'h0, ft}, {63'h0, rsp_fault});
        chk("rsp_perm", {61'h0, pm}, {61'h0, rsp_perm});
        chk("rsp_pa", pa, rsp_pa);
        chk("entry reads", 64'(n), 64'(i_mem.log_q.size()));
        for (int k = 0; k < n; k++) begin
            chk("entry address", ad[k], i_mem.log_q[k]);
        end
    endtask

    // ==========
    // Main sequence
    initial begin
        rstn = 1'b0;
        hsel = 1'b1;
        htrans = 2'b00;
        haddr = 32'h0;
        hwrite = 1'b0;
        hsize = `NPW_HSIZE_WORD;
        hwdata = 32'h0;
        req_valid = 1'b0;
        req_gpa = 64'h0;
        req_acc = 3'h0;
        lat = 4'h0;
        en = 1'b0;
        fails = 0;
        n_checks = 0;
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        ahb_chk(`NPW_OFF_CTRL, 32'h0, "ctrl");
        ahb_chk(`NPW_OFF_STAT, 32'h0, "status");
        ahb(1'b1, `NPW_OFF_IDQ, 32'hFFFF_FFFF);
        ahb_chk(`NPW_OFF_IDQ, 32'(PA_W), "width report");
        ahb_chk(8'h40, 32'h0, "unmapped");
        walk(GA, 3'h7, 4'h0);
        ahb(1'b1, `NPW_OFF_CTRL, 32'h1);
        walk(GA, 3'h2, 4'h0);
        ahb(1'b1, `NPW_OFF_ROOT_LO, ROOT[31:0]);
        ahb(1'b1, `NPW_OFF_ROOT_HI, ROOT[63:32]);
        ahb_chk(`NPW_OFF_ROOT_HI, ROOT[63:32], "root high");
        ahb(1'b1, `NPW_OFF_CTRL, 32'h8000_0001);
        en = 1'b1;
        put(GA, 4, E0, E1, E2, E3);
        put(GB, 3, E0, E1, 64'h0000_0000_5560_0083, 64'h0);
        put(GD, 1, 64'hFFFF_FFFF_FFFF_FFF8, 64'h0, 64'h0, 64'h0);
        // Read, write and fetch, with growing memory delay
        for (int i = 0; i < 3; i++) begin
            walk(GA, 3'h1 << i, 4'(3 * i));
        end
        walk(GB, 3'h3, 4'h2);
        walk(GD, 3'h1, 4'h0);
        walk(GC, 3'h1, 4'h1);
        ahb(1'b0, `NPW_OFF_STAT, 32'h0);
        chk("status", 64'h32, {58'h0, rd[5:0]});
        // Six enabled walks ended, faulted ones included
        chk("walk count", 64'h6, {48'h0, rd[31:16]});
        wrap_up;
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        wrap_up;
    end
endmodule
